// ---- frame_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // =====================================================
  // Storage
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire logic full;
  wire logic empty;
  wire logic push;
  wire logic pop;

  assign full = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  assign empty = (wr_q == rd_q);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full && clk_en;
  assign pop = out_ready && !empty && clk_en;
  assign out_data = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers carry one extra bit so full and empty stay distinct
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
endmodule // frame_fifo
`default_nettype wire

// ---- host_serial_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
  input wire logic sys_clk,
  input wire logic serial_chain_output,
  output logic sclk,
  output logic din,
  output logic sync_n
);
  logic [15:0] captured;
  // ==================================================
  // Idle state
  // Clock idles high, so no stray falling edge is seen outside a frame
  initial begin
    sclk = 1'b1;
    din = 1'b0;
    sync_n = 1'b1;
    captured = 16'h0000;
  end
  // ==================================================
  // Frame driver: 160 ns serial clock, data changed on the rising edge
  task automatic send(input logic [31:0] w, input int n, input int extra);
    @(negedge sys_clk);
    sync_n = 1'b0;
    #80;
    for (int i = 0; i < n + extra; i++) begin
      din = (i < n) ? w[n-1-i] : ~din;
      #80;
      captured = {captured[14:0], serial_chain_output};
      sclk = 1'b0;
      #80;
      sclk = 1'b1;
    end
    #80;
    sync_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule // host_serial_model
`default_nettype wire

// ---- quad_dac_defs.svh ----
`ifndef QUAD_DAC_DEFS_SVH
`define QUAD_DAC_DEFS_SVH
// =====================================================
// Frame layout
`define QD_FRAME_BITS 16
`define QD_ADDR_HI_BIT 15
`define QD_ADDR_LO_BIT 14
`define QD_RANGE_BIT 13
`define QD_REF_BIT 12
`define QD_CODE_MSB 11
`define QD_CODE_BITS 12
// =====================================================
// Reset values and sizes
`define QD_CODE_RESET 12'h000
`define QD_RANGE_RESET 1'b0
`define QD_REF_RESET 1'b0
`define QD_FIFO_DEPTH 16
`define QD_CHANNELS 4
// =====================================================
// Timing
`define QD_SYS_CLK_HZ 50000000
`define QD_SCLK_MAX_HZ 30000000
`define QD_SYNC_STAGES 2
`endif

// ---- quad_dac_pkg.sv ----
package quad_dac_pkg;
  // =====================================================
  // Types
  typedef struct packed {
    logic [1:0] chan;
    logic range_x2;
    logic ref_buf;
    logic [11:0] code;
  } frame_t;

  typedef struct packed {
    logic range_x2;
    logic ref_buf;
    logic [11:0] code;
  } chan_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SHIFT = 3'b010,
    ST_HOLD = 3'b100
  } frame_state_t;
endpackage

// ---- quad_dac_serial_load_control.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "quad_dac_defs.svh"
module quad_dac_serial_load_control #(
  parameter int RESOLUTION = `QD_CODE_BITS,
  parameter int FIFO_DEPTH = `QD_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic sclk,
  input wire logic din,
  input wire logic sync_n,
  input wire logic chain_mode_select,
  input wire logic output_latch_load_n,
  input wire logic async_zero_all_n,
  input wire logic sleep_n,
  output logic serial_chain_output,
  output logic iface_awake,
  output logic analog_enable,
  output logic [4*RESOLUTION-1:0] channel_code,
  output logic [3:0] channel_range_x2,
  output logic [3:0] channel_ref_buf
);
  // =====================================================
  // Pin synchronisers
  localparam int NPIN = 6;
  localparam int FW = $bits(quad_dac_pkg::frame_t);
  logic [NPIN-1:0] meta_q;
  logic [NPIN-1:0] pin_q;
  logic sclk_prev_q;
  wire logic [NPIN-1:0] pins;
  wire logic sclk_s;
  wire logic din_s;
  wire logic sync_s;
  wire logic chain_s;
  wire logic output_latch_load_n_s;
  wire logic sleep_s;
  wire logic sclk_fall;
  wire logic sclk_rise;

  assign pins = {sleep_n, output_latch_load_n, chain_mode_select, sync_n, din, sclk};
  assign sclk_s = pin_q[0];
  assign din_s = pin_q[1];
  assign sync_s = pin_q[2];
  assign chain_s = pin_q[3];
  assign output_latch_load_n_s = pin_q[4];
  assign sleep_s = pin_q[5];
  // Edges come only from the second stage; sclk and din share latency so bits stay aligned
  assign sclk_fall = sclk_prev_q && !sclk_s;
  assign sclk_rise = !sclk_prev_q && sclk_s;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q <= 6'h3D;
      pin_q <= 6'h3D;
      sclk_prev_q <= 1'b1;
    end else if (clk_en) begin
      meta_q <= pins;
      pin_q <= meta_q;
      sclk_prev_q <= sclk_s;
    end
  end

  // =====================================================
  // Frame engine
  quad_dac_pkg::frame_state_t st_q;
  quad_dac_pkg::frame_state_t st_d;
  logic [15:0] shift_q;
  logic [4:0] cnt_q;
  logic sync_prev_q;
  logic commit_q;
  logic [15:0] commit_word_q;
  logic awake_q;
  logic sdo_q;
  wire logic sync_fall;
  wire logic sync_rise;
  wire logic in_shift;
  wire logic take_bit;
  wire logic last_bit;
  wire logic commit_set;
  wire logic [15:0] shift_next;
  wire logic fifo_in_ready;

  assign sync_fall = sync_prev_q && !sync_s;
  assign sync_rise = !sync_prev_q && sync_s;
  assign in_shift = (st_q == quad_dac_pkg::ST_SHIFT);
  // Chain mode drops the 16-edge gate
  assign take_bit = in_shift && !sync_s && sclk_fall;
  assign last_bit = take_bit && !chain_s && (cnt_q == 5'(`QD_FRAME_BITS - 1));
  assign shift_next = {shift_q[14:0], din_s};
  // Standalone commits on the 16th edge, chain mode at select rise after at least 16
  assign commit_set = last_bit ||
    (in_shift && sync_rise && chain_s && (cnt_q == 5'(`QD_FRAME_BITS)));

  always_comb begin
    st_d = st_q;
    case (st_q)
      quad_dac_pkg::ST_IDLE: begin
        if (sync_fall) st_d = quad_dac_pkg::ST_SHIFT;
      end
      quad_dac_pkg::ST_SHIFT: begin
        if (sync_s) st_d = quad_dac_pkg::ST_IDLE;
        else if (last_bit) st_d = quad_dac_pkg::ST_HOLD;
      end
      quad_dac_pkg::ST_HOLD: begin
        if (sync_s) st_d = quad_dac_pkg::ST_IDLE;
      end
      default: st_d = quad_dac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= quad_dac_pkg::ST_IDLE;
      sync_prev_q <= 1'b1;
      shift_q <= 16'h0000;
      cnt_q <= 5'h00;
    end else if (clk_en) begin
      st_q <= st_d;
      sync_prev_q <= sync_s;
      if (sync_fall) cnt_q <= 5'h00;
      else if (take_bit && cnt_q != 5'(`QD_FRAME_BITS)) cnt_q <= cnt_q + 5'h01;
      if (take_bit) shift_q <= shift_next;
    end
  end

  // A finished frame waits here until the buffer takes it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      commit_q <= 1'b0;
      commit_word_q <= 16'h0000;
    end else if (clk_en) begin
      if (commit_set) begin
        commit_q <= 1'b1;
        commit_word_q <= last_bit ? shift_next : shift_q;
      end else if (fifo_in_ready) begin
        commit_q <= 1'b0;
      end
    end
  end

  // Wake state and chain output
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awake_q <= 1'b0;
      sdo_q <= 1'b0;
    end else if (clk_en) begin
      if (sync_fall) awake_q <= 1'b1;
      else if (sync_rise) awake_q <= 1'b0;
      if (sclk_rise && chain_s) sdo_q <= shift_q[15];
    end
  end

  // =====================================================
  // Clear release synchroniser
  // Draining stops at once on the raw pin, but resumes only after a clean two-stage release
  logic [1:0] clear_ok_q;
  wire logic clear_ok;

  assign clear_ok = clear_ok_q[1];

  always_ff @(posedge sys_clk or posedge rst or negedge async_zero_all_n) begin
    if (rst || !async_zero_all_n) begin
      clear_ok_q <= 2'b00;
    end else if (clk_en) begin
      clear_ok_q <= {clear_ok_q[0], 1'b1};
    end
  end

  // =====================================================
  // Frame buffer
  quad_dac_pkg::frame_t push_frame;
  quad_dac_pkg::frame_t pop_frame;
  wire logic [FW-1:0] pop_bits;
  wire logic pop_valid;
  wire logic pop_ready;
  wire logic pop_fire;

  assign push_frame.chan = {commit_word_q[`QD_ADDR_HI_BIT], commit_word_q[`QD_ADDR_LO_BIT]};
  assign push_frame.range_x2 = commit_word_q[`QD_RANGE_BIT];
  assign push_frame.ref_buf = commit_word_q[`QD_REF_BIT];
  assign push_frame.code = commit_word_q[`QD_CODE_MSB:0];
  assign pop_frame = quad_dac_pkg::frame_t'(pop_bits);
  // Draining stalls while clear is held, so buffered frames land after it releases
  assign pop_ready = async_zero_all_n && clear_ok;
  assign pop_fire = pop_valid && pop_ready && clk_en;

  frame_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_frame_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(commit_q),
    .in_ready(fifo_in_ready),
    .in_data(push_frame),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_bits)
  );

  // =====================================================
  // Input and channel registers
  quad_dac_pkg::chan_cfg_t [3:0] in_cfg_q;
  quad_dac_pkg::chan_cfg_t [3:0] dac_cfg_q;
  quad_dac_pkg::chan_cfg_t new_cfg;
  logic [3:0] dirty_q;
  logic enable_q;
  wire logic [3:0] wr;
  wire logic load;
  wire logic [11:0] code_mask;

  function automatic logic [3:0] chan_onehot(input logic [1:0] chan);
    chan_onehot = 4'h1 << chan;
  endfunction

  // Narrow variants drop low bits so codes stay left aligned in the 12-bit field
  assign code_mask = 12'hFFF << (`QD_CODE_BITS - RESOLUTION);
  assign new_cfg.range_x2 = pop_frame.range_x2;
  assign new_cfg.ref_buf = pop_frame.ref_buf;
  assign new_cfg.code = pop_frame.code & code_mask;
  assign wr = pop_fire ? chan_onehot(pop_frame.chan) : 4'h0;
  assign load = !output_latch_load_n_s && clk_en;

  // Clear pin is an asynchronous reset for this bank and for the clear release synchroniser
  always_ff @(posedge sys_clk or posedge rst or negedge async_zero_all_n) begin
    if (rst || !async_zero_all_n) begin
      in_cfg_q <= '0;
      dac_cfg_q <= '0;
      dirty_q <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < `QD_CHANNELS; i++) begin
        if (wr[i]) in_cfg_q[i] <= new_cfg;
        if (load && wr[i]) dac_cfg_q[i] <= new_cfg;
        else if (load && dirty_q[i]) dac_cfg_q[i] <= in_cfg_q[i];
        // A write in the same cycle as a transfer goes straight to the channel register and leaves it clean
        dirty_q[i] <= wr[i] ? !load : (dirty_q[i] && !load);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) enable_q <= 1'b0;
    else if (clk_en) enable_q <= sleep_s;
  end

  // =====================================================
  // Outputs
  assign serial_chain_output = sdo_q;
  assign iface_awake = awake_q;
  assign analog_enable = enable_q;
  for (genvar g = 0; g < 4; g++) begin : g_out
    assign channel_code[g*RESOLUTION +: RESOLUTION] = dac_cfg_q[g].code[11 -: RESOLUTION];
    assign channel_range_x2[g] = dac_cfg_q[g].range_x2;
    assign channel_ref_buf[g] = dac_cfg_q[g].ref_buf;
  end

  // =====================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !async_zero_all_n || !clk_en);

  shift_msb_first_a: assert property (
    take_bit && (chain_s || cnt_q < 5'd16) |=> shift_q == {$past(shift_q[14:0]), $past(din_s)})
    else $error("shift register did not take the bit msb first");
  standalone_ignore_a: assert property (
    st_q == quad_dac_pkg::ST_HOLD |=> $stable(shift_q))
    else $error("shift register moved after sixteenth edge");
  early_abort_a: assert property (
    in_shift && sync_rise && cnt_q < 5'd16 |-> !commit_set)
    else $error("aborted frame was committed");
  addressed_write_a: assert property (
    pop_fire |=> in_cfg_q[$past(pop_frame.chan)] == $past(new_cfg))
    else $error("input register not written from frame");
  load_high_hold_a: assert property (
    output_latch_load_n_s |=> $stable(dac_cfg_q))
    else $error("channel register changed with load high");
  clean_chan_keep_a: assert property (
    !output_latch_load_n_s && !dirty_q[0] && !wr[0] |=> $stable(dac_cfg_q[0]))
    else $error("unchanged channel was updated");
  pending_transfer_a: assert property (
    !output_latch_load_n_s && dirty_q[1] && !wr[1] |=> dac_cfg_q[1] == $past(in_cfg_q[1]) && !dirty_q[1])
    else $error("pending channel not transferred");
  sleep_float_a: assert property (
    !sleep_s ##1 !sleep_s |-> !analog_enable)
    else $error("outputs enabled during sleep");
  chain_out_a: assert property (
    chain_s && sclk_rise |=> serial_chain_output == $past(shift_q[15]))
    else $error("chain output not driven on rising edge");
  wake_follow_a: assert property (
    sync_fall |=> iface_awake)
    else $error("interface not awake after select fall");

  wake_drop_a: assert property (
    sync_rise |=> !iface_awake)
    else $error("interface still awake after select rise");

  commit_word_a: assert property (
    last_bit |=> commit_q && commit_word_q == $past(shift_next))
    else $error("finished frame not held for the buffer");

  code_mask_a: assert property (
    pop_fire |=> (in_cfg_q[$past(pop_frame.chan)].code & ~code_mask) == 12'h000)
    else $error("dropped code bits were kept");

  write_load_a: assert property (
    pop_fire && !output_latch_load_n_s |=> dac_cfg_q[$past(pop_frame.chan)] == $past(new_cfg))
    else $error("frame with load low did not pass to channel register");

  chain_no_gate_a: assert property (
    take_bit && chain_s |=> st_q != quad_dac_pkg::ST_HOLD)
    else $error("chain mode stopped shifting at sixteen edges");

  sleep_wake_a: assert property (
    sleep_s ##1 sleep_s |-> analog_enable)
    else $error("outputs not enabled after sleep released");
endmodule // quad_dac_serial_load_control
`default_nettype wire

// ---- quad_dac_serial_load_control_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_load_control_test;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic chain_mode_select = 1'b0;
  logic output_latch_load_n = 1'b1;
  logic async_zero_all_n = 1'b1;
  logic sleep_n = 1'b1;
  wire logic sclk;
  wire logic din;
  wire logic sync_n;
  logic serial_chain_output;
  logic iface_awake;
  logic analog_enable;
  logic [47:0] channel_code;
  logic [3:0] channel_range_x2;
  logic [3:0] channel_ref_buf;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h42C2;
  quad_dac_pkg::chan_cfg_t in_q [4];
  quad_dac_pkg::chan_cfg_t out_q [4];
  logic [3:0] dirty = 4'h0;
  quad_dac_pkg::frame_t f1;
  quad_dac_pkg::frame_t f2;

  always #10 sys_clk = ~sys_clk;

  quad_dac_serial_load_control #(.RESOLUTION(12), .FIFO_DEPTH(16)) DUT (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .sclk(sclk), .din(din), .sync_n(sync_n),
    .chain_mode_select(chain_mode_select), .output_latch_load_n(output_latch_load_n),
    .async_zero_all_n(async_zero_all_n), .sleep_n(sleep_n), .serial_chain_output(serial_chain_output),
    .iface_awake(iface_awake), .analog_enable(analog_enable), .channel_code(channel_code),
    .channel_range_x2(channel_range_x2), .channel_ref_buf(channel_ref_buf));

  host_serial_model host (.sys_clk(sys_clk), .serial_chain_output(serial_chain_output),
    .sclk(sclk), .din(din), .sync_n(sync_n));

  // ==================================================
  // Helpers
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic check_outputs();
    for (int c = 0; c < 4; c++) begin
      cmp({2'b00, channel_range_x2[c], channel_ref_buf[c], channel_code[c*12 +: 12]}, {2'b00, out_q[c]}, "channel");
    end
  endtask

  // Load pin is a level; only channels written since their last update move
  task automatic pulse_load();
    output_latch_load_n = 1'b0;
    cycles(10);
    output_latch_load_n = 1'b1;
    cycles(5);
    for (int c = 0; c < 4; c++) begin
      if (dirty[c]) out_q[c] = in_q[c];
    end
    dirty = 4'h0;
  endtask

  task automatic write(input logic [1:0] ch, input logic load_low, input int extra);
    f1 = quad_dac_pkg::frame_t'(next_rand()); 
    f1.chan = ch;
    output_latch_load_n = ~load_low;
    fork
      host.send({16'h0000, f1}, 16, extra);
      begin
        #400;
        cmp({15'h0000, iface_awake}, 16'h0001, "awake in frame");
      end
    join
    cmp({15'h0000, iface_awake}, 16'h0000, "asleep after frame");
    in_q[ch] = {f1.range_x2, f1.ref_buf, f1.code};
    // Load held low also moves every channel still pending
    if (load_low) begin
      for (int c = 0; c < 4; c++) begin
        if (dirty[c]) out_q[c] = in_q[c];
      end
      dirty = 4'h0;
      out_q[ch] = in_q[ch];
    end else dirty[ch] = 1'b1;
    output_latch_load_n = 1'b1;
    cycles(5);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==================================================
  // Watchdog: the sequence needs well under a third of this span
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end

  // ==================================================
  // Main sequence
  initial begin
    for (int c = 0; c < 4; c++) begin
      in_q[c] = '0;
      out_q[c] = '0;
    end
    cycles(16);
    rst = 1'b0;
    cycles(5);
    check_outputs();
    for (int i = 0; i < 8; i++) begin
      write(i[1:0], 1'b0, 0);
      check_outputs();
    end
    pulse_load();
    check_outputs();
    write(2'd1, 1'b0, 0);
    pulse_load();
    check_outputs();
    host.send(next_rand(), 10, 0);
    pulse_load();
    check_outputs();
    write(2'd2, 1'b1, 4);
    check_outputs();
    async_zero_all_n = 1'b0;
    #3;
    for (int c = 0; c < 4; c++) begin
      in_q[c] = '0;
      out_q[c] = '0;
    end
    dirty = 4'h0;
    check_outputs();
    cycles(2);
    async_zero_all_n = 1'b1;
    cycles(5);
    pulse_load();
    check_outputs();
    sleep_n = 1'b0;
    cycles(6);
    cmp({15'h0000, analog_enable}, 16'h0000, "sleep");
    write(2'd3, 1'b1, 0);
    check_outputs();
    sleep_n = 1'b1;
    cycles(6);
    cmp({15'h0000, analog_enable}, 16'h0001, "wake");
    chain_mode_select = 1'b1;
    cycles(5);
    f1 = quad_dac_pkg::frame_t'(next_rand());
    f2 = quad_dac_pkg::frame_t'(next_rand());
    output_latch_load_n = 1'b0;
    host.send({f1, f2}, 32, 0);
    cycles(10);
    output_latch_load_n = 1'b1;
    in_q[f2.chan] = {f2.range_x2, f2.ref_buf, f2.code};
    out_q[f2.chan] = in_q[f2.chan];
    cmp(host.captured, f1, "chain out");
    check_outputs();
    chain_mode_select = 1'b0;
    cycles(5);
    // Random mix of held and transparent loads between explicit updates
    for (int i = 0; i < 12; i++) begin
      write(2'(next_rand()), 1'(next_rand()), 0);
      if (i % 3 == 2) pulse_load();
      check_outputs();
    end
    print_verdict();
  end
endmodule // quad_dac_serial_load_control_test
`default_nettype wire
